/* pkg/dbgua_pkg.sv */
// Overview of operation
// - Idle transmit line stays high; receiver idles high.
// - Frame: low start, eight LSB-first, high stop.
// - Status bit 4 flags low stop bit.
// - Status bit 3 copies prior receive-full.
// - Bit 2 sets on receive, clears on read.
// - Bit 1 shows transmit holding register occupied.
// - Bit 0 shows transmit shifter running.
// - Low data read: byte low, upper zero.
// - Receive interrupt on every completed byte transfer.
// - Low data write sends bits 7:0 only.
// - Idle transmitter: load, interrupt, start at once.
// - Busy transmitter: hold byte until frame ends.
// - High data register mirrors low, bits 15:8.
// - Holding register empties when its byte starts.
// - Receiver detects start on falling edge while idle.
// - Eight data bits sampled mid-bit, LSB first.
// - After byte and flags, receiver returns idle.
// - Rate is clock over (prescale+1) times period.
// - Divider register resets to zero.
// - Receiver samples on the prescaler output tick.
package dbgua_pkg;

    // Register addresses on the processor data bus.
    localparam logic [15:0] ADDR_FLAGS     = 16'hc028;
    localparam logic [15:0] ADDR_BYTE_LOW  = 16'hc029;
    localparam logic [15:0] ADDR_BYTE_HIGH = 16'hc02a;
    localparam logic [15:0] ADDR_DIVIDER   = 16'hc02b;

    // Field layout of the divider pair and reset values.
    localparam int          PRESCALE_LSB   = 8;
    localparam int          PERIOD_LSB     = 0;
    localparam logic [15:0] DIVIDER_RESET  = 16'h0000;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;

    // Frame shape: start, eight data bits, stop.
    localparam int          DATA_BITS      = 8;
    localparam int          FRAME_BITS     = 10;
    localparam logic [3:0]  LAST_DATA_IDX  = 4'h7;
    localparam logic [3:0]  LAST_FRAME_IDX = 4'h9;

    // Status word, packed from bit 4 down to bit 0.
    typedef struct packed {
        logic stop_bit_error_flag;     // Bit 4.
        logic receive_overwrite_flag;  // Bit 3.
        logic receive_holding_full;    // Bit 2.
        logic transmit_holding_full;   // Bit 1.
        logic transmit_shifter_active; // Bit 0.
    } dbgua_flags_type;

    // Transmitter states.
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } dbgua_tx_state_type;

    // Receiver states.
    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } dbgua_rx_state_type;

endpackage

/* verilog/dbgua_top.sv */
`timescale 1ns/1ps
module dbgua_top (
    input  wire logic        clk_i,             // 10 MHz master clock.
    input  wire logic        sys_rst_i,         // Async reset, active high.
    input  wire logic [15:0] addr_i,            // Register address.
    input  wire logic        wr_i,              // Write strobe.
    input  wire logic        rd_i,              // Read strobe.
    input  wire logic [15:0] wdata_i,           // Write data.
    output logic      [15:0] rdata_o,           // Read data, next cycle.
    input  wire logic        rxd_i,             // Serial receive line.
    output logic             txd_o,             // Serial transmit line.
    output logic             transmit_started_irq_o, // One-cycle pulse.
    output logic             byte_received_irq_o     // One-cycle pulse.
);

    // Address decode.
    logic sel_flags;
    logic sel_low;
    logic sel_high;
    logic sel_div;
    logic data_wr;
    logic data_rd;
    assign sel_flags = (addr_i == dbgua_pkg::ADDR_FLAGS);
    assign sel_low   = (addr_i == dbgua_pkg::ADDR_BYTE_LOW);
    assign sel_high  = (addr_i == dbgua_pkg::ADDR_BYTE_HIGH);
    assign sel_div   = (addr_i == dbgua_pkg::ADDR_DIVIDER);
    assign data_wr   = wr_i && (sel_low || sel_high);
    assign data_rd   = rd_i && (sel_low || sel_high);

    // The written byte comes from the lane of the register addressed.
    logic [7:0] wr_byte;
    assign wr_byte = sel_high ? wdata_i[15:8] : wdata_i[7:0];

    // Divider register; zero after reset so boot code must set it.
    logic [15:0] div_q;
    logic [7:0]  prescale_divider;
    logic [7:0]  bit_period_divider;
    assign prescale_divider   = div_q[dbgua_pkg::PRESCALE_LSB +: 8];
    assign bit_period_divider = div_q[dbgua_pkg::PERIOD_LSB +: 8];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_q <= dbgua_pkg::DIVIDER_RESET;
        end else if (wr_i && sel_div) begin
            div_q <= wdata_i;
        end
    end

    // Prescaler: one sample tick every prescale_divider + 1 clocks.
    logic [7:0] pre_cnt_q;
    logic       tick;
    assign tick = (pre_cnt_q == prescale_divider);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pre_cnt_q <= 8'h00;
        end else if (tick) begin
            pre_cnt_q <= 8'h00;
        end else begin
            pre_cnt_q <= pre_cnt_q + 8'h01;
        end
    end

    // Bit period end: the period divider wraps after its full count.
    // A zero divider behaves as 256 ticks; software must avoid it.
    logic [7:0] period_last;
    assign period_last = bit_period_divider - 8'h01;

    // ---------------- Transmitter ----------------
    dbgua_pkg::dbgua_tx_state_type tx_state_q;
    logic [9:0] tx_shift_q;
    logic [7:0] tx_hold_q;
    logic       tx_hold_full_q;
    logic [7:0] tx_div_q;
    logic [3:0] tx_bit_q;
    logic       tx_irq_q;
    logic       tx_active;
    logic       tx_bit_end;
    logic       tx_frame_end;
    logic       tx_load_now;
    logic       tx_load_held;
    logic       tx_free;

    assign tx_active    = (tx_state_q == dbgua_pkg::TX_SHIFT);
    assign tx_bit_end   = tx_active && tick && (tx_div_q == period_last);
    assign tx_frame_end = tx_bit_end &&
                          (tx_bit_q == dbgua_pkg::LAST_FRAME_IDX);
    // Software is trusted not to write while the holding byte waits.
    // A write in the last stop-bit cycle goes straight to the shifter,
    // otherwise the byte would wait in holding with the shifter idle.
    assign tx_free      = !tx_active || tx_frame_end;
    assign tx_load_now  = data_wr && tx_free && !tx_hold_full_q;
    assign tx_load_held = tx_frame_end && tx_hold_full_q;

    // Transmit state and shifter; the line reads the shifter LSB.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_state_q <= dbgua_pkg::TX_IDLE;
            tx_shift_q <= 10'h3ff;
            tx_div_q   <= 8'h00;
            tx_bit_q   <= 4'h0;
        end else if (tx_load_now || tx_load_held) begin
            tx_state_q <= dbgua_pkg::TX_SHIFT;
            tx_shift_q <= {1'b1, (tx_load_now ? wr_byte : tx_hold_q),
                           1'b0};
            tx_div_q   <= 8'h00;
            tx_bit_q   <= 4'h0;
        end else if (tx_frame_end) begin
            tx_state_q <= dbgua_pkg::TX_IDLE;
            tx_shift_q <= 10'h3ff;
        end else if (tx_bit_end) begin
            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
            tx_div_q   <= 8'h00;
            tx_bit_q   <= tx_bit_q + 4'h1;
        end else if (tx_active && tick) begin
            tx_div_q   <= tx_div_q + 8'h01;
        end
    end

    assign txd_o = tx_shift_q[0];

    // Holding register: fills only while busy, empties on load.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_hold_q      <= dbgua_pkg::BYTE_RESET;
            tx_hold_full_q <= 1'b0;
        end else if (data_wr && !tx_load_now && !tx_hold_full_q) begin
            tx_hold_q      <= wr_byte;
            tx_hold_full_q <= 1'b1;
        end else if (tx_load_held) begin
            tx_hold_full_q <= 1'b0;
        end
    end

    // Transmit interrupt pulses on every shifter load.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_irq_q <= 1'b0;
        end else begin
            tx_irq_q <= tx_load_now || tx_load_held;
        end
    end

    assign transmit_started_irq_o = tx_irq_q;

    // ---------------- Receiver ----------------
    dbgua_pkg::dbgua_rx_state_type rx_state_q;
    logic       rxd_prev_q;
    logic [7:0] rx_div_q;
    logic [7:0] rx_shift_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_data_q;
    logic       rx_full_q;
    logic       rx_orun_q;
    logic       rx_ferr_q;
    logic       rx_irq_q;
    logic       rx_start_seen;
    logic       rx_sample;
    logic       rx_done;

    // A high-to-low step on the line while idle begins a frame.
    assign rx_start_seen = (rx_state_q == dbgua_pkg::RX_IDLE) &&
                           rxd_prev_q && !rxd_i;
    assign rx_sample     = (rx_state_q != dbgua_pkg::RX_IDLE) && tick &&
                           (rx_div_q == 8'h00);
    assign rx_done       = rx_sample &&
                           (rx_state_q == dbgua_pkg::RX_STOP);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rxd_prev_q <= 1'b1;
        end else begin
            rxd_prev_q <= rxd_i;
        end
    end

    // Sample timer: half a bit to the start centre, then whole bits.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_div_q <= 8'h00;
        end else if (rx_start_seen) begin
            rx_div_q <= {1'b0, bit_period_divider[7:1]};
        end else if (rx_sample) begin
            rx_div_q <= period_last;
        end else if (tick && rx_div_q != 8'h00) begin
            rx_div_q <= rx_div_q - 8'h01;
        end
    end

    // Receive sequencer. A start bit found high at its centre is
    // taken as a glitch and dropped, which avoids false frames.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_state_q <= dbgua_pkg::RX_IDLE;
            rx_shift_q <= dbgua_pkg::BYTE_RESET;
            rx_bit_q   <= 3'h0;
        end else if (rx_start_seen) begin
            rx_state_q <= dbgua_pkg::RX_START;
        end else if (rx_sample) begin
            unique case (rx_state_q)
                dbgua_pkg::RX_START: begin
                    rx_state_q <= rxd_i ? dbgua_pkg::RX_IDLE
                                        : dbgua_pkg::RX_DATA;
                    rx_bit_q   <= 3'h0;
                end
                dbgua_pkg::RX_DATA: begin
                    rx_shift_q <= {rxd_i, rx_shift_q[7:1]};
                    rx_bit_q   <= rx_bit_q + 3'h1;
                    if ({1'b0, rx_bit_q} == dbgua_pkg::LAST_DATA_IDX) begin
                        rx_state_q <= dbgua_pkg::RX_STOP;
                    end
                end
                dbgua_pkg::RX_STOP: begin
                    rx_state_q <= dbgua_pkg::RX_IDLE;
                end
                dbgua_pkg::RX_IDLE: begin
                    rx_state_q <= dbgua_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // Byte transfer and receive flags; a new byte beats a read.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_data_q <= dbgua_pkg::BYTE_RESET;
            rx_full_q <= 1'b0;
            rx_orun_q <= 1'b0;
            rx_ferr_q <= 1'b0;
        end else if (rx_done) begin
            rx_data_q <= rx_shift_q;
            rx_ferr_q <= !rxd_i;
            rx_orun_q <= rx_full_q;
            rx_full_q <= 1'b1;
        end else if (data_rd) begin
            rx_full_q <= 1'b0;
        end
    end

    // Receive interrupt pulses on every transfer.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_irq_q <= 1'b0;
        end else begin
            rx_irq_q <= rx_done;
        end
    end

    assign byte_received_irq_o = rx_irq_q;

    // ---------------- Read path ----------------
    dbgua_pkg::dbgua_flags_type flags;
    assign flags.stop_bit_error_flag     = rx_ferr_q;
    assign flags.receive_overwrite_flag  = rx_orun_q;
    assign flags.receive_holding_full    = rx_full_q;
    assign flags.transmit_holding_full   = tx_hold_full_q;
    assign flags.transmit_shifter_active = tx_active;

    // Unmapped addresses read as zero.
    logic [15:0] rd_mux;
    assign rd_mux = sel_flags ? {11'h000, flags} :
                    sel_low   ? {8'h00, rx_data_q} :
                    sel_high  ? {rx_data_q, 8'h00} :
                    sel_div   ? div_q : 16'h0000;

    logic [15:0] rdata_q;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= 16'h0000;
        end else if (rd_i) begin
            rdata_q <= rd_mux;
        end
    end

    assign rdata_o = rdata_q;

    // ---------------- Checks ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence seq_idle_write;
        data_wr && !tx_active && !tx_hold_full_q;
    endsequence

    sequence seq_frame_begins;
        tx_irq_q && tx_active && !txd_o;
    endsequence

    a_idle_line_high: assert property (
        !tx_active |-> txd_o)
        else $error("Transmit line low while idle.");

    a_write_idle_go: assert property (
        seq_idle_write |=> seq_frame_begins)
        else $error("Idle write did not start a frame.");

    a_write_busy_hold: assert property (
        data_wr && tx_active && !tx_frame_end |=> tx_hold_full_q)
        else $error("Busy write did not fill holding register.");

    a_hold_empties: assert property (
        tx_frame_end && tx_hold_full_q |=> !tx_hold_full_q ##0
        seq_frame_begins)
        else $error("Held byte not launched at frame end.");

    a_stop_bit_high: assert property (
        tx_frame_end |-> txd_o && $past(txd_o))
        else $error("Stop bit not high.");

    a_frame_error: assert property (
        rx_done |=> rx_ferr_q == !$past(rxd_i))
        else $error("Framing flag does not follow stop bit.");

    a_overrun_copy: assert property (
        rx_done |=> rx_orun_q == $past(rx_full_q))
        else $error("Overrun flag not copied from full flag.");

    a_read_clears: assert property (
        data_rd && !rx_done |=> !rx_full_q)
        else $error("Data read did not clear full flag.");

    a_rx_irq_full: assert property (
        rx_done |=> byte_received_irq_o && rx_full_q &&
        rx_state_q == dbgua_pkg::RX_IDLE)
        else $error("Received byte without interrupt.");

    a_low_upper_zero: assert property (
        rd_i && sel_low |=> rdata_o[15:8] == 8'h00 &&
        rdata_o[7:0] == $past(rx_data_q))
        else $error("Low data read returned wrong value.");

    a_high_lower_zero: assert property (
        rd_i && sel_high |=> rdata_o[7:0] == 8'h00 &&
        rdata_o[15:8] == $past(rx_data_q))
        else $error("High data read returned wrong value.");

    a_edge_write_go: assert property (
        data_wr && tx_frame_end && !tx_hold_full_q |=>
        seq_frame_begins and !tx_hold_full_q)
        else $error("Write at frame end was not launched.");

    a_tx_irq_cause: assert property (
        transmit_started_irq_o |-> $rose(tx_active) ||
        $past(tx_frame_end))
        else $error("Transmit interrupt without a load.");

    a_start_detect: assert property (
        rx_start_seen |=> rx_state_q == dbgua_pkg::RX_START)
        else $error("Falling edge did not begin reception.");

endmodule

/* test/dbgua_term_model.sv */
`timescale 1ns/1ps
// Remote terminal model: drives the receive line, decodes the transmit line.
module dbgua_term_model #(
    parameter int BIT_CLKS = 6     // Clocks per bit, (P+1)*D.
) (
    input  wire logic clk_i,       // Master clock.
    input  wire logic txd_i,       // Line from the block.
    output logic      rxd_o        // Line into the block.
);
    logic [7:0] got_q[$];          // Decoded bytes in arrival order.
    logic       stop_seen;         // Level of the last stop bit seen.

    // The line rests high between frames.
    initial rxd_o = 1'b1;

    // Send one frame; a low stop bit forces a framing fault on purpose.
    task automatic send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] fr;
        fr = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o = fr[i];
            repeat (BIT_CLKS) @(posedge clk_i);
            #10;
        end
        rxd_o = 1'b1;
    endtask

    // A one-clock low pulse that a sound receiver must not take as a start.
    task automatic glitch();
        rxd_o = 1'b0;
        @(posedge clk_i);
        #10;
        rxd_o = 1'b1;
    endtask

    // Samples fall mid-bit, so they never meet an edge of the line.
    always begin : decode_frame
        logic [7:0] b;
        @(negedge txd_i);
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            b[i] = txd_i;
        end
        repeat (BIT_CLKS) @(posedge clk_i);
        stop_seen = txd_i;
        got_q.push_back(b);
    end
endmodule

/* test/debug_serial_uart_bench.sv */
`timescale 1ns/1ps
module debug_serial_uart_bench;
    typedef struct {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [7:0]  exp;
    } dbgua_tx_row_type;
    typedef struct {
        logic [7:0]  data;
        logic        stop;
        logic [15:0] raddr;
        logic [15:0] flags;
        logic [15:0] rdata;
        logic [15:0] after;
    } dbgua_rx_row_type;

    logic        clk_i     = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [15:0] addr_i    = 16'h0000;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic [15:0] wdata_i   = 16'h0000;
    logic [15:0] rdata_o;
    logic        rxd_i;
    logic        txd_o;
    logic        transmit_started_irq_o;
    logic        byte_received_irq_o;
    logic [15:0] rd;
    logic        wr_irq;
    logic        wr_line;
    int          err_count = 0;
    int          checked   = 0;
    int          tx_irq    = 0;
    int          rx_irq    = 0;
    int          n;

    // Reset state of every register, plus an unmapped place.
    logic [15:0] rst_addr[5] = '{16'hc028, 16'hc029, 16'hc02a, 16'hc02b,
                                 16'hc02c};
    dbgua_tx_row_type tx_rows[3] = '{
        '{16'hc029, 16'hab55, 8'h55},
        '{16'hc02a, 16'h3c77, 8'h3c},
        '{16'hc029, 16'hff80, 8'h80}};
    // Zero read address means the byte is left unread.
    dbgua_rx_row_type rx_rows[4] = '{
        '{8'ha5, 1'b1, 16'hc029, 16'h0004, 16'h00a5, 16'h0000},
        '{8'h3c, 1'b0, 16'h0000, 16'h0014, 16'h0000, 16'h0000},
        '{8'hc3, 1'b1, 16'hc02a, 16'h000c, 16'hc300, 16'h0008},
        '{8'h01, 1'b1, 16'hc029, 16'h0004, 16'h0001, 16'h0000}};

    always #50 clk_i = ~clk_i;

    dbgua_top dut_u (
        .clk_i                  (clk_i),
        .sys_rst_i              (sys_rst_i),
        .addr_i                 (addr_i),
        .wr_i                   (wr_i),
        .rd_i                   (rd_i),
        .wdata_i                (wdata_i),
        .rdata_o                (rdata_o),
        .rxd_i                  (rxd_i),
        .txd_o                  (txd_o),
        .transmit_started_irq_o (transmit_started_irq_o),
        .byte_received_irq_o    (byte_received_irq_o)
    );

    dbgua_term_model #(.BIT_CLKS(6)) term_u (
        .clk_i (clk_i),
        .txd_i (txd_o),
        .rxd_o (rxd_i)
    );

    // Pulses are counted, since their exact cycle shifts with tick phase.
    always @(posedge clk_i) begin
        if (transmit_started_irq_o === 1'b1)
            tx_irq++;
        if (byte_received_irq_o === 1'b1)
            rx_irq++;
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // A spare cycle after each access keeps a strobe from toggling twice.
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(posedge clk_i);
        #10;
        wr_irq = transmit_started_irq_o;
        wr_line = txd_o;
        wr_i = 1'b0;
        @(posedge clk_i);
        #10;
    endtask

    task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
        addr_i = a;
        rd_i = 1'b1;
        @(posedge clk_i);
        #10;
        d = rdata_o;
        rd_i = 1'b0;
        @(posedge clk_i);
        #10;
    endtask

    // Waits for the model to hold n bytes, then past their stop bit.
    task automatic wait_tx(input int cnt);
        for (int k = 0; k < 4000 && term_u.got_q.size() < cnt; k++)
            @(posedge clk_i);
        repeat (6) @(posedge clk_i);
        #10;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        #10;
        sys_rst_i = 1'b0;
        foreach (rst_addr[i]) begin
            reg_rd(rst_addr[i], rd);
            check("reset value", rd, 16'h0000);
        end
        check("idle line", {15'h0000, txd_o}, 16'h0001);
        reg_wr(16'hc02b, 16'h0006);
        reg_wr(16'hc028, 16'h001f);
        reg_rd(16'hc02b, rd);
        check("divider", rd, 16'h0006);
        reg_rd(16'hc028, rd);
        check("flags after write", rd, 16'h0000);
        $display("test reset and divider done");
        foreach (tx_rows[i]) begin
            reg_wr(tx_rows[i].addr, tx_rows[i].wdata);
            check("start irq", {15'h0000, wr_irq}, 16'h0001);
            check("start bit", {15'h0000, wr_line}, 16'h0000);
            reg_rd(16'hc028, rd);
            check("tx flags", rd, 16'h0001);
            wait_tx(i + 1);
            check("tx byte", {8'h00, term_u.got_q[i]},
                  {8'h00, tx_rows[i].exp});
            check("stop bit", {15'h0000, term_u.stop_seen}, 16'h0001);
        end
        $display("test transmit table done");
        // Second write lands while the shifter is busy and holding is empty.
        n = tx_irq;
        reg_wr(16'hc029, 16'h005a);
        reg_wr(16'hc029, 16'h00a6);
        reg_rd(16'hc028, rd);
        check("held flags", rd, 16'h0003);
        check("one start", 16'(tx_irq - n), 16'h0001);
        for (int k = 0; k < 200 && tx_irq - n < 2; k++)
            @(posedge clk_i);
        #10;
        reg_rd(16'hc028, rd);
        check("holding freed", rd, 16'h0001);
        wait_tx(5);
        check("first byte", {8'h00, term_u.got_q[3]}, 16'h005a);
        check("second byte", {8'h00, term_u.got_q[4]}, 16'h00a6);
        check("idle after", {15'h0000, txd_o}, 16'h0001);
        $display("test back to back done");
        n = rx_irq;
        term_u.glitch();
        repeat (80) @(posedge clk_i);
        #10;
        check("glitch ignored", 16'(rx_irq - n), 16'h0000);
        foreach (rx_rows[i]) begin
            n = rx_irq;
            term_u.send_byte(rx_rows[i].data, rx_rows[i].stop);
            repeat (2) @(posedge clk_i);
            #10;
            check("rx irq", 16'(rx_irq - n), 16'h0001);
            reg_rd(16'hc028, rd);
            check("rx flags", rd, rx_rows[i].flags);
            if (rx_rows[i].raddr != 16'h0000) begin
                reg_rd(rx_rows[i].raddr, rd);
                check("rx data", rd, rx_rows[i].rdata);
                reg_rd(16'hc028, rd);
                check("read clears", rd, rx_rows[i].after);
            end
        end
        $display("test receive table done");
        // Second write is sampled on the very edge that ends the frame.
        reg_wr(16'hc029, 16'h0069);
        repeat (58) @(posedge clk_i);
        #10;
        reg_wr(16'hc029, 16'h0096);
        check("edge start", {15'h0000, wr_irq}, 16'h0001);
        check("edge line", {15'h0000, wr_line}, 16'h0000);
        wait_tx(7);
        check("edge first", {8'h00, term_u.got_q[5]}, 16'h0069);
        check("edge byte", {8'h00, term_u.got_q[6]}, 16'h0096);
        $display("test write at frame end done");
        reg_wr(16'hc029, 16'h0011);
        repeat (10) @(posedge clk_i);
        #10;
        sys_rst_i = 1'b1;
        @(posedge clk_i);
        #10;
        check("line in reset", {15'h0000, txd_o}, 16'h0001);
        sys_rst_i = 1'b0;
        reg_rd(16'hc02b, rd);
        check("divider reset", rd, 16'h0000);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
